/* File: rtl/tmo_top.sv */
// Timer output flip-flop, prescaler and input edge selection
//
// Contract
// (RULE1) Software trigger write launches a one-shot pulse; bit always reads 0.
// (RULE2) Pulse select bit: 0 successive pulses, 1 one-shot pulse.
// (RULE3) Invert enable B toggles output flip-flop on each compare B match.
// (RULE4) Invert enable A toggles output flip-flop on each compare A match.
// (RULE5) Force set/reset pair: 00 keep, 01 clear, 10 set, 11 prohibited.
// (RULE6) Force set and force reset bits always read as 0.
// (RULE7) Output disabled holds pin at 0; enabled pin follows the flip-flop.
// (RULE8) One-shot only in free-running and clear-on-input-A-edge modes.
// (RULE9) Software stops the timer before writing output control bits.
// (RULE10) Software writes the trigger only when one-shot mode is selected.
// (RULE11) Repeated triggers are spaced two count clocks apart by software.
// (RULE12) While output disabled, enable and force bits written in one byte.
// (RULE13) Prescale bits 7:6 pick input B edge: fall, rise, both.
// (RULE14) Prescale bits 5:4 pick input A edge: fall, rise, both.
// (RULE15) Prescale bits 1:0 pick count clock: /1, /4, /256, input A edge.
// (RULE16) External count pulses on input A last over two system clocks.
// (RULE17) Software stops the timer before writing the prescale register.
// (RULE18) Input A count clock excludes clear-and-start or capture on input A.
// (RULE19) Edge reference level is frozen while stopped, compared on restart.
// (RULE20) Noise filter needs two equal samples; sample rate per use of pin.
// (RULE21) Shared pin is either input B or timer output, never both.
// (RULE22) Port two direction: 0 output, 1 input, reset all ones.
// (RULE23) Simultaneous match events toggle once; forced level lands next clock.
`timescale 1ns/1ps
module tmo_top
   import tmo_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic [15:0] addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [7:0]  rdata,
   input  wire logic [1:0]  counter_mode,
   input  wire logic        invert_on_edge_a,
   input  wire logic        match_a,
   input  wire logic        match_b,
   input  wire logic        counter_overflow,
   input  wire logic        timer_input_a,
   input  wire logic        timer_input_b,
   output logic             count_tick,
   output logic             in_a_valid_edge,
   output logic             in_b_valid_edge,
   output logic             oneshot_active,
   output logic             timer_output_pin,
   output logic             shared_port_pin_oe,
   output logic      [7:0]  port_two_direction
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] prescale;
      logic [7:0] out_ctrl;
      logic [7:0] port_dir;
      logic [7:0] rdata;
      logic [7:0] div;
      logic       tick;
      logic       samp_a;
      logic       ref_a;
      logic       edge_a;
      logic       samp_b;
      logic       ref_b;
      logic       edge_b;
      logic       out_ff;
      logic       armed;
      logic       pin;
      logic       pin_oe;
   } tmo_state_t;

   localparam tmo_state_t STATE_RST = '{
      prescale: PRESCALE_RST,
      out_ctrl: OUT_CTRL_RST,
      port_dir: PORT2_DIR_RST,
      rdata:    8'h00,
      div:      8'h00,
      tick:     1'b0,
      samp_a:   1'b0,
      ref_a:    1'b0,
      edge_a:   1'b0,
      samp_b:   1'b0,
      ref_b:    1'b0,
      edge_b:   1'b0,
      out_ff:   1'b0,
      armed:    1'b0,
      pin:      1'b0,
      pin_oe:   1'b0
   };

   tmo_state_t s;
   tmo_state_t next_s;
   logic [1:0] rst_sync;
   logic       rst_n;

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end

   assign rst_n = rst_sync[1];

   // ----------------------------------------
   // Edge qualifier for a two-bit edge select
   // ----------------------------------------
   function automatic logic edge_match(input logic [1:0] sel,
                                       input logic       new_lvl);
      logic hit;
      hit = 1'b0;
      unique case (sel)
         EDGE_FALL: hit = !new_lvl;
         EDGE_RISE: hit = new_lvl;
         EDGE_BOTH: hit = 1'b1;
         default:   hit = 1'b0;
      endcase
      return hit;
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   logic       run;
   logic [1:0] clk_sel;
   logic [1:0] pin_in;
   logic [1:0] strobe;
   logic [1:0] listen;
   logic [1:0] take;
   logic [1:0] fresh;
   logic [1:0] samp_q;
   logic [1:0] ref_q;
   logic [1:0] next_samp;
   logic [1:0] next_ref;
   logic [1:0] next_edge;
   logic [3:0] edge_sel;
   logic       in_b_mode;
   logic       wr_ctrl;
   logic       oneshot_ok;
   logic       toggle;

   // ----------------------------------------
   // Input filters, one per timer input pin
   // ----------------------------------------
   assign pin_in   = {timer_input_b, timer_input_a};
   assign samp_q   = {s.samp_b, s.samp_a};
   assign ref_q    = {s.ref_b, s.ref_a};
   assign listen   = {in_b_mode, 1'b1}; // RULE21
   assign edge_sel = {s.prescale[PS_EDGE_B_LO +: 2], s.prescale[PS_EDGE_A_LO +: 2]};

   for (genvar ch = 0; ch < 2; ch++) begin : g_in
      // Sampled every clock when pin A drives the count, else on the count tick
      assign strobe[ch]    = (clk_sel == CLK_SEL_EXT_A) || s.tick; // RULE20
      assign take[ch]      = strobe[ch] && listen[ch];
      // Two equal samples that differ from the frozen reference make an edge
      assign fresh[ch]     = run && (samp_q[ch] == pin_in[ch]) && (pin_in[ch] != ref_q[ch]); // RULE19 RULE20
      assign next_samp[ch] = take[ch] ? pin_in[ch] : samp_q[ch];
      assign next_ref[ch]  = (take[ch] && fresh[ch]) ? pin_in[ch] : ref_q[ch]; // RULE19
      assign next_edge[ch] = take[ch] && fresh[ch]
                             && edge_match(edge_sel[2*ch +: 2], pin_in[ch]); // RULE13 RULE14
   end

   always_comb begin
      next_s     = s;
      run        = counter_mode != MODE_STOP;
      clk_sel    = s.prescale[PS_CLK_SEL_LO +: 2];
      in_b_mode  = s.port_dir[PORT2_BIT_IN_B];
      wr_ctrl    = wr && (addr == ADDR_OUT_CTRL);
      oneshot_ok = (counter_mode == MODE_FREE_RUN) || (counter_mode == MODE_CS_EDGE); // RULE8
      // Register reads, one cycle later
      next_s.rdata = 8'h00;
      if (rd) begin
         unique case (addr)
            ADDR_PRESCALE:  next_s.rdata = s.prescale;
            ADDR_OUT_CTRL:  next_s.rdata = s.out_ctrl; // RULE1 RULE6
            ADDR_PORT2_DIR: next_s.rdata = s.port_dir;
            default:        next_s.rdata = 8'h00;
         endcase
      end

      // Register writes
      if (wr && (addr == ADDR_PRESCALE)) begin
         next_s.prescale = wdata & PRESCALE_MASK; // RULE13 RULE14 RULE15
      end
      if (wr_ctrl) begin
         next_s.out_ctrl = wdata & OUT_CTRL_MASK; // RULE1 RULE6
      end
      if (wr && (addr == ADDR_PORT2_DIR)) begin
         next_s.port_dir = wdata; // RULE22
      end

      // ----------------------------------------
      // Input filter results
      // ----------------------------------------
      next_s.samp_a = next_samp[0];
      next_s.ref_a  = next_ref[0];
      next_s.edge_a = next_edge[0]; // RULE14
      next_s.samp_b = next_samp[1];
      next_s.ref_b  = next_ref[1];
      next_s.edge_b = next_edge[1]; // RULE13

      // Count clock selection
      next_s.div  = run ? s.div + 8'h01 : 8'h00;
      next_s.tick = 1'b0;
      unique case (clk_sel)
         CLK_SEL_DIV1:   next_s.tick = run; // RULE15
         CLK_SEL_DIV4:   next_s.tick = run && (s.div[1:0] == DIV4_LAST); // RULE15
         CLK_SEL_DIV256: next_s.tick = run && (s.div == DIV256_LAST); // RULE15
         CLK_SEL_EXT_A:  next_s.tick = next_s.edge_a; // RULE15
      endcase

      // One-shot window: opened by trigger, closed by overflow
      if (counter_overflow) begin
         next_s.armed = 1'b0; // RULE8
      end
      if (s.out_ctrl[OC_ONESHOT_MODE] && oneshot_ok) begin // RULE2 RULE8
         if (wr_ctrl && wdata[OC_SW_TRIGGER]) begin
            next_s.armed = 1'b1; // RULE1
         end
         if (s.edge_a && (counter_mode == MODE_CS_EDGE)) begin
            next_s.armed = 1'b1; // RULE8
         end
      end

      // Output flip-flop: at most one toggle per clock, software force wins
      toggle = (match_a && s.out_ctrl[OC_INVERT_A]) // RULE4
             || (match_b && s.out_ctrl[OC_INVERT_B]) // RULE3
             || (s.edge_a && invert_on_edge_a); // RULE23
      if (s.out_ctrl[OC_ONESHOT_MODE] && !s.armed) begin
         toggle = 1'b0; // RULE2
      end
      if (toggle) begin
         next_s.out_ff = !s.out_ff; // RULE3 RULE4 RULE23
      end
      if (wr_ctrl) begin
         unique case ({wdata[OC_FORCE_SET], wdata[OC_FORCE_RESET]})
            2'h1:    next_s.out_ff = 1'b0; // RULE5 RULE23
            2'h2:    next_s.out_ff = 1'b1; // RULE5 RULE23
            default: next_s.out_ff = next_s.out_ff; // RULE5
         endcase
      end

      // Pin drive
      next_s.pin    = next_s.out_ctrl[OC_TIMER_OUT_ENABLE] && next_s.out_ff; // RULE7
      next_s.pin_oe = !next_s.port_dir[PORT2_BIT_IN_B]; // RULE21 RULE22
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s <= STATE_RST;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign rdata              = s.rdata;
   assign count_tick         = s.tick;
   assign in_a_valid_edge    = s.edge_a;
   assign in_b_valid_edge    = s.edge_b;
   assign oneshot_active     = s.armed;
   assign timer_output_pin   = s.pin;
   assign shared_port_pin_oe = s.pin_oe;
   assign port_two_direction = s.port_dir;
endmodule

/* File: rtl/tmo_pkg.sv */
// Constants for the timer output and prescaler/edge-select block
package tmo_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [15:0] ADDR_PRESCALE  = 16'hff61;
   localparam logic [15:0] ADDR_OUT_CTRL  = 16'hff63;
   localparam logic [15:0] ADDR_PORT2_DIR = 16'hff22;

   // ----------------------------------------
   // Reset values and writable masks
   // ----------------------------------------
   localparam logic [7:0] PRESCALE_RST  = 8'h00;
   localparam logic [7:0] OUT_CTRL_RST  = 8'h00;
   localparam logic [7:0] PORT2_DIR_RST = 8'hff;
   localparam logic [7:0] PRESCALE_MASK = 8'hf3;
   localparam logic [7:0] OUT_CTRL_MASK = 8'h33;

   // ----------------------------------------
   // Output control field positions
   // ----------------------------------------
   localparam int OC_TIMER_OUT_ENABLE = 0;
   localparam int OC_INVERT_A         = 1;
   localparam int OC_FORCE_RESET      = 2;
   localparam int OC_FORCE_SET        = 3;
   localparam int OC_INVERT_B         = 4;
   localparam int OC_ONESHOT_MODE     = 5;
   localparam int OC_SW_TRIGGER       = 6;

   // ----------------------------------------
   // Prescale and port two direction field positions and encodings
   // ----------------------------------------
   localparam int PS_CLK_SEL_LO  = 0;
   localparam int PS_EDGE_A_LO   = 4;
   localparam int PS_EDGE_B_LO   = 6;
   localparam int PORT2_BIT_IN_B = 1;

   localparam logic [1:0] CLK_SEL_DIV1   = 2'h0;
   localparam logic [1:0] CLK_SEL_DIV4   = 2'h1;
   localparam logic [1:0] CLK_SEL_DIV256 = 2'h2;
   localparam logic [1:0] CLK_SEL_EXT_A  = 2'h3;
   localparam logic [1:0] DIV4_LAST      = 2'h3;
   localparam logic [7:0] DIV256_LAST    = 8'hff;

   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // ----------------------------------------
   // Counter mode codes seen from the mode register
   // ----------------------------------------
   localparam logic [1:0] MODE_STOP     = 2'h0;
   localparam logic [1:0] MODE_FREE_RUN = 2'h1;
   localparam logic [1:0] MODE_CS_EDGE  = 2'h2;
   localparam logic [1:0] MODE_CS_MATCH = 2'h3;
endpackage

/* File: testbench/tmo_pin_src.sv */
// Pulse source standing on the two timer input pins
`timescale 1ns/1ps
module tmo_pin_src (
   input  wire logic       clk_sys,
   input  wire logic       lvl,
   input  wire logic [1:0] lag,
   output logic            pin_a,
   output logic            pin_b
);
   logic [1:0] cnt;
   initial begin
      pin_a = 1'b0;
      pin_b = 1'b0;
      cnt = 2'h0;
   end
   // Follows the requested level after lag cycles, prompt when lag is 0
   always @(posedge clk_sys) begin
      if (pin_a == lvl) begin
         cnt <= lag;
      end else if (cnt != 2'h0) begin
         cnt <= cnt - 2'h1;
      end else begin
         pin_a <= lvl;
         pin_b <= lvl;
      end
   end
endmodule

/* File: testbench/tmo_top_props.sv */
// Port checks for the timer output block
`timescale 1ns/1ps
module tmo_top_props
   import tmo_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        nrst,
   input wire logic [15:0] addr,
   input wire logic [7:0]  wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [7:0]  rdata,
   input wire logic [1:0]  counter_mode,
   input wire logic        invert_on_edge_a,
   input wire logic        match_a,
   input wire logic        match_b,
   input wire logic        timer_input_a,
   input wire logic        count_tick,
   input wire logic        in_a_valid_edge,
   input wire logic        timer_output_pin,
   input wire logic        shared_port_pin_oe,
   input wire logic [7:0]  port_two_direction
);
   logic [7:0] oc;
   logic [7:0] ps;
   logic       wr_oc;
   logic       tgl;
   logic       quiet;
   assign wr_oc = wr && addr == ADDR_OUT_CTRL;
   assign tgl = match_a && oc[OC_INVERT_A] || match_b && oc[OC_INVERT_B];
   assign quiet = !wr_oc && !invert_on_edge_a && !oc[OC_ONESHOT_MODE]
                  && counter_mode != MODE_STOP;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         oc <= 8'h00;
         ps <= 8'h00;
      end else if (wr && addr == ADDR_PRESCALE) begin
         ps <= wdata;
      end else if (wr_oc) begin
         oc <= wdata;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence s_gap4;
      (!count_tick) [*3] ##1 (count_tick || counter_mode == MODE_STOP);
   endsequence
   a_ctrl_read_masked:
      assert property (rd && addr == ADDR_OUT_CTRL |=> rdata[7:6] == 2'h0 && rdata[3:2] == 2'h0)
      else $error("control bits read back nonzero");
   a_pin_disabled_low:
      assert property (wr_oc && !wdata[0] |=> !timer_output_pin)
      else $error("pin not low while disabled");
   a_force_set_high:
      assert property (wr_oc && wdata[3:0] == 4'h9 |=> timer_output_pin)
      else $error("forced set did not land");
   a_match_toggles_pin:
      assert property (tgl && quiet && oc[0] |=> timer_output_pin != $past(timer_output_pin))
      else $error("match did not toggle pin");
   a_pin_holds_idle:
      assert property (!tgl && quiet |=> $stable(timer_output_pin))
      else $error("pin moved without cause");
   a_dir_drives_oe:
      assert property (wr && addr == ADDR_PORT2_DIR |=> port_two_direction == $past(wdata)
                       && shared_port_pin_oe == !port_two_direction[1])
      else $error("direction or enable wrong");
   a_div4_spacing:
      assert property (count_tick && ps[1:0] == CLK_SEL_DIV4 && counter_mode != MODE_STOP
                       |=> s_gap4)
      else $error("divide by four spacing wrong");
   a_edge_two_samples:
      assert property (in_a_valid_edge && ps[1:0] == CLK_SEL_EXT_A |-> $past(timer_input_a)
         == $past(timer_input_a, 2) && (ps[5:4] != EDGE_RISE || $past(timer_input_a)))
      else $error("edge accepted without two samples");
endmodule
bind tmo_top tmo_top_props u_props (.clk_sys, .nrst, .addr, .wdata, .wr, .rd, .rdata,
   .counter_mode, .invert_on_edge_a, .match_a, .match_b, .timer_input_a, .count_tick,
   .in_a_valid_edge, .timer_output_pin, .shared_port_pin_oe, .port_two_direction);

/* File: testbench/timer_output_and_edge_prescaler_tb.sv */
// Self-checking bench for the timer output and prescaler block
`timescale 1ns/1ps
module timer_output_and_edge_prescaler_tb;
   import tmo_pkg::*;
   logic        clk_sys = 1'b0;
   logic        nrst = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [1:0]  mode = 2'h0;
   logic        ma = 1'b0;
   logic        mb = 1'b0;
   logic        ovf = 1'b0;
   logic        lvl = 1'b0;
   logic [1:0]  lag = 2'h0;
   logic        iea = 1'b0;
   logic [7:0]  rdata;
   logic [7:0]  dir;
   logic        tick, ea, eb, osa, pin, oe, sa, sb;
   int          mismatches = 0;
   int          samples_checked = 0;
   int          na, nb, nt;
   always #12.5 clk_sys = ~clk_sys;
   always @(negedge clk_sys) begin
      na += int'(ea === 1'b1);
      nb += int'(eb === 1'b1);
      nt += int'(tick === 1'b1);
   end
   tmo_pin_src u_src (.clk_sys, .lvl, .lag, .pin_a(sa), .pin_b(sb));
   // Shared pin carries the timer output while its driver is enabled
   tmo_top u_dut (.clk_sys, .nrst, .addr, .wdata, .wr, .rd, .rdata, .counter_mode(mode),
      .invert_on_edge_a(iea), .match_a(ma), .match_b(mb), .counter_overflow(ovf),
      .timer_input_a(sa), .timer_input_b(oe ? pin : sb), .count_tick(tick),
      .in_a_valid_edge(ea), .in_b_valid_edge(eb), .oneshot_active(osa),
      .timer_output_pin(pin), .shared_port_pin_oe(oe), .port_two_direction(dir));
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic wreg(input logic [15:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      cyc(1);
      wr <= 1'b0;
      cyc(1);
   endtask
   task automatic rchk(input logic [15:0] a, input logic [7:0] e);
      addr <= a;
      rd <= 1'b1;
      cyc(1);
      rd <= 1'b0;
      @(negedge clk_sys);
      chk("rdata", {8'h00, e}, {8'h00, rdata});
      cyc(1);
   endtask
   task automatic mt(input logic a, input logic b);
      ma <= a;
      mb <= b;
      cyc(1);
      ma <= 1'b0;
      mb <= 1'b0;
      cyc(1);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      #400000;
      mismatches++;
      conclude();
   end
   initial begin
      logic [1:0] e;
      cyc(2);
      nrst <= 1'b1;
      cyc(6);
      rchk(ADDR_PRESCALE, 8'h00);
      rchk(ADDR_OUT_CTRL, 8'h00);
      rchk(ADDR_PORT2_DIR, 8'hff);
      rchk(16'hff60, 8'h00);
      wreg(ADDR_PRESCALE, 8'hff);
      rchk(ADDR_PRESCALE, 8'hf3);
      wreg(ADDR_OUT_CTRL, 8'h77);
      rchk(ADDR_OUT_CTRL, 8'h33);
      wreg(ADDR_PRESCALE, 8'h00);
      wreg(ADDR_OUT_CTRL, 8'h0b);
      chk("pin", 1, pin);
      mode <= MODE_FREE_RUN;
      mt(1'b1, 1'b0);
      chk("pin", 0, pin);
      mt(1'b0, 1'b1);
      chk("pin", 0, pin);
      mode <= MODE_STOP;
      wreg(ADDR_OUT_CTRL, 8'h17);
      mode <= MODE_FREE_RUN;
      mt(1'b1, 1'b1);
      chk("pin", 1, pin);
      mt(1'b0, 1'b1);
      chk("pin", 0, pin);
      mode <= MODE_STOP;
      wreg(ADDR_OUT_CTRL, 8'h08);
      chk("pin", 0, pin);
      wreg(ADDR_OUT_CTRL, 8'h01);
      chk("pin", 1, pin);
      wreg(ADDR_OUT_CTRL, 8'h21);
      mode <= MODE_FREE_RUN;
      wreg(ADDR_OUT_CTRL, 8'h61);
      cyc(1);
      chk("oneshot", 1, osa);
      ovf <= 1'b1;
      cyc(1);
      ovf <= 1'b0;
      cyc(2);
      chk("oneshot", 0, osa);
      mode <= MODE_CS_MATCH;
      wreg(ADDR_OUT_CTRL, 8'h61);
      cyc(1);
      chk("oneshot", 0, osa);
      for (int s = 0; s < 3; s++) begin
         mode <= MODE_STOP;
         wreg(ADDR_PRESCALE, {6'h00, 2'(s)});
         mode <= MODE_FREE_RUN;
         cyc(8);
         nt = 0;
         cyc(1024);
         chk("ticks", 16'(1024 >> (s == 0 ? 0 : s == 1 ? 2 : 8)), 16'(nt));
      end
      for (int k = 0; k < 3; k++) begin
         e = k == 0 ? EDGE_FALL : k == 1 ? EDGE_RISE : EDGE_BOTH;
         mode <= MODE_STOP;
         wreg(ADDR_PRESCALE, {e, e, 2'h0, CLK_SEL_EXT_A});
         mode <= MODE_FREE_RUN;
         cyc(4);
         na = 0;
         nb = 0;
         nt = 0;
         lag <= 2'h0;
         lvl <= 1'b1;
         cyc(1);
         lvl <= 1'b0;
         cyc(4);
         lag <= 2'h3;
         repeat (2) begin
            lvl <= 1'b1;
            cyc(8);
            lvl <= 1'b0;
            cyc(8);
         end
         chk("edges a", e == EDGE_BOTH ? 4 : 2, 16'(na));
         chk("edges b", e == EDGE_BOTH ? 4 : 2, 16'(nb));
         chk("ticks", e == EDGE_BOTH ? 4 : 2, 16'(nt));
      end
      mode <= MODE_STOP;
      wreg(ADDR_PRESCALE, {EDGE_RISE, EDGE_RISE, 2'h0, CLK_SEL_EXT_A});
      wreg(ADDR_OUT_CTRL, 8'h05);
      iea <= 1'b1;
      lvl <= 1'b1;
      cyc(8);
      na = 0;
      mode <= MODE_FREE_RUN;
      cyc(8);
      chk("restart edge", 1, 16'(na));
      chk("pin", 1, pin);
      iea <= 1'b0;
      mode <= MODE_STOP;
      wreg(ADDR_PORT2_DIR, 8'hfd);
      chk("oe", 1, oe);
      chk("dir", 8'hfd, dir);
      wreg(ADDR_PORT2_DIR, 8'hff);
      chk("oe", 0, oe);
      conclude();
   end
endmodule
